//--- design/cmw_top.sv
// command decoder and mode registers for compare setup
// Functional notes
// - finish maximum, 32-bit, no axis select
// - multi-axis command loads all selected
// - interpolation mode ignores axis select
// - data word then command copies
// - reset clears all mode bits
// - four 4-bit fields per compare
// - source codes logical real speed timer
// - relation codes ge gt eq lt
// - results drive output, sync, interrupt
// - size status readable regardless relation
`timescale 1ns/1ps
module cmw_top
   import cmw_pkg::*;
#(
   parameter int AXES = NUM_AXES
)
(
   // clock and reset
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   // host write side
   input  wire logic [15:0]       write_data_low_i,
   input  wire logic [15:0]       write_data_high_i,
   input  wire logic [7:0]        command_reg_i,
   input  wire logic [AXES-1:0]   axis_sel_i,
   input  wire logic              command_we_i,
   // per-axis compare sources, axis-major
   input  wire logic [AXES*32-1:0] logical_position_i,
   input  wire logic [AXES*32-1:0] real_position_i,
   input  wire logic [AXES*32-1:0] current_speed_i,
   input  wire logic [AXES*32-1:0] current_timer_i,
   // mode and parameter outputs
   output logic [AXES*16-1:0]     compare_mode_setting_o,
   output logic [15:0]            interp_mode_o,
   output logic [31:0]            finish_max_o,
   output logic                   busy_o,
   // compare results
   output logic [AXES*4-1:0]      compare_hit_o,
   output logic [AXES*8-1:0]      compare_status_read_o
);
   typedef struct packed
   {
      cmw_state_e                 state;
      logic [3:0]                 wait_cnt;
      logic [AXES-1:0][15:0]      mode;
      logic [AXES-1:0][3:0][31:0] gcr;
      logic [15:0]                interp;
      logic [31:0]                finish;
   } cmw_top_s;
   cmw_top_s st_reg;
   cmw_top_s st_next;
   logic [31:0] data_word;

   assign data_word = {write_data_high_i, write_data_low_i};

   // command decode and register load
   always_comb
   begin
      st_next = st_reg;
      unique case (st_reg.state)
         CMW_IDLE:
         begin
            if (command_we_i)
            begin
               st_next.state    = CMW_BUSY;
               st_next.wait_cnt = 4'(ACCESS_CYC);
               for (int a = 0; a < AXES; a++)
               begin
                  // same word to all selected axes
                  if (axis_sel_i[a] && command_reg_i == CMD_CMP_MODE)
                     st_next.mode[a] = write_data_low_i;
                  for (int k = 0; k < NUM_CMP; k++)
                     if (axis_sel_i[a] &&
                         command_reg_i == CMD_GCR0 + 8'(k))
                        st_next.gcr[a][k] = data_word;
               end
               if (command_reg_i == CMD_INTERP_MODE)
                  st_next.interp = write_data_low_i;
               // finish maximum, axis free, range kept
               if (command_reg_i == CMD_FINISH_MAX &&
                   data_word >= FINISH_MIN && data_word <= FINISH_MAX)
                  st_next.finish = data_word;
            end
         end
         CMW_BUSY:
         begin
            st_next.wait_cnt = st_reg.wait_cnt - 4'h1;
            if (st_reg.wait_cnt == 4'h1)
               st_next.state = CMW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_reg.state    <= CMW_IDLE;
         st_reg.wait_cnt <= 4'h0;
         st_reg.mode     <= '0;
         st_reg.gcr      <= '0;
         st_reg.interp   <= '0;
         st_reg.finish   <= FINISH_RESET;
      end
      else
         st_reg <= st_next;
   end

   assign finish_max_o  = st_reg.finish;
   assign interp_mode_o = st_reg.interp;
   assign busy_o        = st_reg.state == CMW_BUSY;

   // per-axis comparators
   for (genvar a = 0; a < AXES; a++)
   begin : g_axis
      cmw_cmp_if cif ();
      assign cif.mode   = st_reg.mode[a];
      assign cif.src[0] = logical_position_i[32*a +: 32];
      assign cif.src[1] = real_position_i[32*a +: 32];
      assign cif.src[2] = current_speed_i[32*a +: 32];
      assign cif.src[3] = current_timer_i[32*a +: 32];
      for (genvar k = 0; k < NUM_CMP; k++)
      begin : g_val
         assign cif.gcr[k] = st_reg.gcr[a][k];
      end
      cmw_compare u_cmp
      (
         .clock_i (clock_i),
         .rstn_i  (rstn_i),
         .bus     (cif)
      );
      assign compare_mode_setting_o[16*a +: 16] = st_reg.mode[a];
      // hit flags for output, sync, interrupt
      assign compare_hit_o[4*a +: 4] = cif.hit;
      // ge in low nibble, lt in high
      assign compare_status_read_o[8*a +: 8] = {cif.lt, cif.ge};
   end

   a_mode_load: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (st_reg.state == CMW_IDLE && command_we_i && axis_sel_i[0] &&
       command_reg_i == CMD_CMP_MODE)
      |=> st_reg.mode[0] == $past(write_data_low_i))
      else $error("mode not loaded");
   a_mode_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (!axis_sel_i[0] || !command_we_i) |=> $stable(st_reg.mode[0]))
      else $error("unselected mode changed");
   a_interp_free: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (st_reg.state == CMW_IDLE && command_we_i &&
       command_reg_i == CMD_INTERP_MODE)
      |=> interp_mode_o == $past(write_data_low_i))
      else $error("interp mode not loaded");
   a_finish_rng: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $changed(finish_max_o) |-> finish_max_o >= FINISH_MIN &&
      finish_max_o <= FINISH_MAX)
      else $error("finish maximum out of range");
   a_busy_len: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $rose(busy_o) |-> busy_o [*8] ##1 busy_o [*7] ##1 !busy_o)
      else $error("access window length wrong");
   a_reset_zero: assert property (@(posedge clock_i)
      !rstn_i |-> compare_mode_setting_o == '0)
      else $error("mode not cleared by reset");

   a_reset_busy: assert property (@(posedge clock_i)
      !rstn_i |-> !busy_o && interp_mode_o == '0 &&
      finish_max_o == FINISH_RESET)
      else $error("reset left state behind");

   a_busy_start: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (st_reg.state == CMW_IDLE && command_we_i)
      |=> busy_o)
      else $error("busy not raised");

   // strobes inside the window are refused
   a_busy_refuse: assert property (@(posedge clock_i) disable iff (!rstn_i)
      busy_o
      |=> $stable(compare_mode_setting_o))
      else $error("mode changed while busy");

   a_busy_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
      busy_o
      |=> $stable(interp_mode_o) && $stable(finish_max_o))
      else $error("parameter changed while busy");

   a_idle_quiet: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (!busy_o && !command_we_i)
      |=> !busy_o)
      else $error("busy without command");

   a_wait_range: assert property (@(posedge clock_i) disable iff (!rstn_i)
      busy_o
      |-> st_reg.wait_cnt != 4'h0 && st_reg.wait_cnt <= 4'(ACCESS_CYC))
      else $error("window counter out of range");

   a_gcr0_load: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (st_reg.state == CMW_IDLE && command_we_i && axis_sel_i[0] &&
       command_reg_i == CMD_GCR0)
      |=> st_reg.gcr[0][0] == $past(data_word))
      else $error("compare value 0 not loaded");

   a_gcr3_load: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (st_reg.state == CMW_IDLE && command_we_i && axis_sel_i[0] &&
       command_reg_i == CMD_GCR3)
      |=> st_reg.gcr[0][3] == $past(data_word))
      else $error("compare value 3 not loaded");

   a_gcr_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !command_we_i
      |=> $stable(st_reg.gcr))
      else $error("compare value drifted");

   a_finish_load: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (st_reg.state == CMW_IDLE && command_we_i &&
       command_reg_i == CMD_FINISH_MAX &&
       data_word >= FINISH_MIN && data_word <= FINISH_MAX)
      |=> finish_max_o == $past(data_word))
      else $error("finish maximum not loaded");

   a_finish_low: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (command_we_i && command_reg_i == CMD_FINISH_MAX &&
       data_word == 32'h0000_0000)
      |=> $stable(finish_max_o))
      else $error("zero finish maximum taken");

   a_finish_high: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (command_we_i && command_reg_i == CMD_FINISH_MAX &&
       data_word > FINISH_MAX)
      |=> $stable(finish_max_o))
      else $error("oversize finish maximum taken");

   // last axis loads the same word
   a_mode_last: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (st_reg.state == CMW_IDLE && command_we_i &&
       axis_sel_i[AXES-1] && command_reg_i == CMD_CMP_MODE)
      |=> st_reg.mode[AXES-1] == $past(write_data_low_i))
      else $error("last axis mode not loaded");

   // two selected axes end up equal
   a_axes_same: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (st_reg.state == CMW_IDLE && command_we_i && axis_sel_i[0] &&
       axis_sel_i[AXES-1] && command_reg_i == CMD_CMP_MODE)
      |=> st_reg.mode[0] == st_reg.mode[AXES-1])
      else $error("selected axes differ");

   // only the mode command writes modes
   a_mode_other: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (command_reg_i != CMD_CMP_MODE)
      |=> $stable(compare_mode_setting_o))
      else $error("mode written by other code");

   a_interp_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (!command_we_i || command_reg_i != CMD_INTERP_MODE)
      |=> $stable(interp_mode_o))
      else $error("interp mode drifted");

   // loads with no axis selected at all
   a_interp_nosel: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (st_reg.state == CMW_IDLE && command_we_i && axis_sel_i == '0 &&
       command_reg_i == CMD_INTERP_MODE)
      |=> interp_mode_o == $past(write_data_low_i))
      else $error("interp mode needs selection");
endmodule

//--- common/cmw_pkg.sv
// shared constants and types for the compare mode command block
package cmw_pkg;
   // command codes
   localparam logic [7:0] CMD_FINISH_MAX = 8'h19;
   localparam logic [7:0] CMD_CMP_MODE   = 8'h20;
   localparam logic [7:0] CMD_INTERP_MODE = 8'h2A;
   localparam logic [7:0] CMD_GCR0       = 8'h10;
   localparam logic [7:0] CMD_GCR3       = 8'h13;
   // register layout
   localparam int NUM_AXES     = 2;
   localparam int NUM_CMP      = 4;
   localparam int FIELD_W      = 4;
   localparam int SRC_LSB      = 0;
   localparam int REL_LSB      = 2;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [31:0] FINISH_RESET = 32'h0000_0000;
   localparam logic [31:0] FINISH_MIN = 32'h0000_0001;
   localparam logic [31:0] FINISH_MAX = 32'h7FFF_FFFE;
   localparam logic [31:0] GCR_RESET  = 32'h0000_0000;
   // command access time
   localparam int ACCESS_NS    = 125;
   localparam int CLK_PERIOD_NS = 8;
   localparam int ACCESS_CYC   = ACCESS_NS / CLK_PERIOD_NS;
   // compare source and relation codes
   localparam logic [1:0] SRC_LOGICAL = 2'h0;
   localparam logic [1:0] SRC_REAL    = 2'h1;
   localparam logic [1:0] SRC_SPEED   = 2'h2;
   localparam logic [1:0] SRC_TIMER   = 2'h3;
   localparam logic [1:0] REL_GE      = 2'h0;
   localparam logic [1:0] REL_GT      = 2'h1;
   localparam logic [1:0] REL_EQ      = 2'h2;
   localparam logic [1:0] REL_LT      = 2'h3;
   typedef enum logic [0:0] {CMW_IDLE, CMW_BUSY} cmw_state_e;
endpackage

//--- common/cmw_cmp_if.sv
// carrier between command decoder and per-axis comparator
`timescale 1ns/1ps
interface cmw_cmp_if;
   logic [15:0] mode;
   logic [31:0] gcr [4];
   logic [31:0] src [4];
   logic [3:0]  hit;
   logic [3:0]  ge;
   logic [3:0]  lt;
   modport ctrl (output mode, output gcr, output src,
                 input hit, input ge, input lt);
   modport cmp  (input mode, input gcr, input src,
                 output hit, output ge, output lt);
endinterface

//--- design/cmw_compare.sv
// four compare channels of one axis
`timescale 1ns/1ps
module cmw_compare
   import cmw_pkg::*;
(
   // clock and reset
   input  wire logic clock_i,
   input  wire logic rstn_i,
   // carrier
   cmw_cmp_if.cmp    bus
);
   typedef struct packed
   {
      logic [3:0] hit;
      logic [3:0] ge;
      logic [3:0] lt;
   } cmw_cmp_s;
   cmw_cmp_s st_reg;
   cmw_cmp_s st_next;
   logic [1:0]  sel_src [NUM_CMP];
   logic [1:0]  sel_rel [NUM_CMP];
   logic [31:0] val [NUM_CMP];

   // source mux per channel
   for (genvar k = 0; k < NUM_CMP; k++)
   begin : g_ch
      assign sel_src[k] = bus.mode[FIELD_W*k+SRC_LSB +: 2];
      assign sel_rel[k] = bus.mode[FIELD_W*k+REL_LSB +: 2];
      assign val[k] = bus.src[sel_src[k]];
   end

   // relation evaluation
   always_comb
   begin
      st_next = st_reg;
      for (int k = 0; k < NUM_CMP; k++)
      begin
         st_next.ge[k] = $signed(val[k]) >= $signed(bus.gcr[k]);
         st_next.lt[k] = $signed(val[k]) < $signed(bus.gcr[k]);
         unique case (sel_rel[k])
            REL_GE: st_next.hit[k] = st_next.ge[k];
            REL_GT: st_next.hit[k] = $signed(val[k]) > $signed(bus.gcr[k]);
            REL_EQ: st_next.hit[k] = val[k] == bus.gcr[k];
            REL_LT: st_next.hit[k] = st_next.lt[k];
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign bus.hit = st_reg.hit;
   assign bus.ge  = st_reg.ge;
   assign bus.lt  = st_reg.lt;

   // equality result one cycle after match
   a_eq_result: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (sel_rel[0] == REL_EQ && val[0] == bus.gcr[0]) |=> st_reg.hit[0])
      else $error("equality hit missing");
   // ge and lt never both set
   // flags are still zero from reset on the first edge after release
   a_size_excl: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $past(rstn_i) |->
      !(st_reg.ge[1] && st_reg.lt[1]) && (st_reg.ge[1] || st_reg.lt[1]))
      else $error("size status inconsistent");
endmodule

//--- testbench/cmw_host.sv
// host model that writes data words and command codes
`timescale 1ns/1ps
module cmw_host
   import cmw_pkg::*;
(
   // clock and device status
   input  wire logic        clock_i,
   input  wire logic        busy_i,
   // command and data words
   output logic [15:0]      data_low_o,
   output logic [15:0]      data_high_o,
   output logic [7:0]       code_o,
   output logic [1:0]       sel_o,
   output logic             we_o
);
   // idle values from time zero
   initial
   begin
      data_low_o = 16'h0000;
      data_high_o = 16'h0000;
      code_o = 8'h00;
      sel_o = 2'b00;
      we_o = 1'b0;
   end
   // data word placed with the code
   task automatic strobe(input logic [7:0] c, input logic [1:0] s,
                         input logic [31:0] v);
   begin
      @(posedge clock_i);
      #1;
      data_low_o = v[15:0];
      data_high_o = v[31:16];
      code_o = c;
      sel_o = s;
      we_o = 1'b1;
      @(posedge clock_i);
      #1;
      we_o = 1'b0;
   end
   endtask
   // nothing new until the access window ends
   task automatic write_cmd(input logic [7:0] c, input logic [1:0] s,
                            input logic [31:0] v);
      int n;
   begin
      strobe(c, s, v);
      n = 0;
      while (busy_i !== 1'b0 && n < 40)
      begin
         @(posedge clock_i);
         #1;
         n++;
      end
   end
   endtask
endmodule

//--- testbench/test_compare_mode_command_writes.sv
// self-checking bench for the compare mode command block
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("[FAIL] %0t got %h want %h", $time, got, exp); \
      end \
   end
module test_compare_mode_command_writes;
   import cmw_pkg::*;
   logic        clock_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [15:0] wdl;
   logic [15:0] wdh;
   logic [7:0]  code;
   logic [1:0]  sel;
   logic        we;
   logic [63:0] srcv [4] = '{default: 64'h0000_0000_0000_0000};
   logic [31:0] mode_o;
   logic [15:0] interp_o;
   logic [31:0] finish_o;
   logic        busy;
   logic [7:0]  hit_o;
   logic [15:0] stat_o;
   int          fail_count = 0;
   int          n_tests = 0;
   int          cycles = 0;
   // expected hits for value 20 against values 10,20,30,40
   logic [3:0]  exp_hit [4] = '{4'b0011, 4'b0001, 4'b0010, 4'b1100};
   // 8 ns clock
   always #4 clock_i = ~clock_i;
   cmw_top i_dut (.clock_i(clock_i), .rstn_i(rstn_i),
      .write_data_low_i(wdl), .write_data_high_i(wdh),
      .command_reg_i(code), .axis_sel_i(sel), .command_we_i(we),
      .logical_position_i(srcv[0]), .real_position_i(srcv[1]),
      .current_speed_i(srcv[2]), .current_timer_i(srcv[3]),
      .compare_mode_setting_o(mode_o), .interp_mode_o(interp_o),
      .finish_max_o(finish_o), .busy_o(busy),
      .compare_hit_o(hit_o), .compare_status_read_o(stat_o));
   cmw_host i_host (.clock_i(clock_i), .busy_i(busy), .data_low_o(wdl),
      .data_high_o(wdh), .code_o(code), .sel_o(sel), .we_o(we));
   task automatic end_of_test();
   begin
      if (fail_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   // every source and relation on axis 0; wrong source gives no hits, except all four under lt
   task automatic sweep();
      logic [15:0] m;
   begin
      for (int k = 0; k < 4; k++)
         i_host.write_cmd(CMD_GCR0 + 8'(k), 2'b01, 32'(10 * k + 10));
      // speed sources held still, equality safe
      for (int s = 0; s < 4; s++)
         for (int r = 0; r < 4; r++)
         begin
            for (int i = 0; i < 4; i++)
               srcv[i][31:0] = (i == s) ? 32'h0000_0014 : 32'hFFFF_FF9C;
            m = {4{r[1:0], s[1:0]}};
            i_host.write_cmd(CMD_CMP_MODE, 2'b01, {16'h0000, m});
            `CHK(mode_o[15:0], m)
            `CHK(hit_o[3:0], exp_hit[r])
            `CHK(stat_o[7:0], 8'hC3)
         end
      // axis 1: mode 1234, zero sources and values
      `CHK(hit_o[7:4], 4'b1110)
      `CHK(stat_o[15:8], 8'h0F)
   end
   endtask
   // hang guard, far above the few hundred cycles needed
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (8) @(posedge clock_i);
      #1;
      rstn_i = 1'b1;
      `CHK(mode_o, 32'h0000_0000)
      `CHK(finish_o, FINISH_RESET)
      `CHK(interp_o, MODE_RESET)
      i_host.write_cmd(CMD_CMP_MODE, 2'b11, 32'hDEAD_A5C3);
      `CHK(mode_o, 32'hA5C3_A5C3)
      i_host.write_cmd(CMD_CMP_MODE, 2'b10, 32'h0000_1234);
      `CHK(mode_o, 32'h1234_A5C3)
      // second strobe lands inside the access window
      i_host.strobe(CMD_CMP_MODE, 2'b01, 32'h0000_0F0F);
      `CHK(busy, 1'b1)
      i_host.write_cmd(CMD_CMP_MODE, 2'b01, 32'h0000_FFFF);
      `CHK(mode_o, 32'h1234_0F0F)
      i_host.write_cmd(CMD_FINISH_MAX, 2'b00, FINISH_MAX);
      `CHK(finish_o, FINISH_MAX)
      i_host.write_cmd(CMD_FINISH_MAX, 2'b00, 32'h7FFF_FFFF);
      `CHK(finish_o, FINISH_MAX)
      i_host.write_cmd(CMD_FINISH_MAX, 2'b00, 32'h0000_0000);
      `CHK(finish_o, FINISH_MAX)
      i_host.write_cmd(CMD_FINISH_MAX, 2'b00, FINISH_MIN);
      `CHK(finish_o, FINISH_MIN)
      i_host.write_cmd(CMD_INTERP_MODE, 2'b00, 32'h0000_5A5A);
      `CHK(interp_o, 16'h5A5A)
      sweep();
      // second reset in mid-run
      rstn_i = 1'b0;
      repeat (8) @(posedge clock_i);
      #1;
      rstn_i = 1'b1;
      `CHK(mode_o, 32'h0000_0000)
      `CHK(finish_o, FINISH_RESET)
      `CHK(busy, 1'b0)
      end_of_test();
   end
endmodule
